// ===== rtl/cvb_top.sv
`timescale 1ns/1ps
module cvb_top
	import cvb_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic [ADDR_W-1:0]           bus_addr_n,
	input  wire logic                        bank_address_n,
	input  wire logic                        bus_read_not_write,
	input  wire logic                        bus_active_n,
	input  wire logic                        bus_phase2,
	input  wire logic                        bus_reset_n,
	input  wire logic [DATA_W-1:0]           bus_data_n_in,
	output logic [DATA_W-1:0]                bus_data_n_out,
	output logic                             bus_data_n_oe,
	input  wire logic [ADDR_W-BLK_LSB-1:0]   base_select_jmp,
	input  wire logic                        bank_select_jmp,
	input  wire logic                        bank_only_jmp,
	input  wire logic                        rom_disable_jmp,
	input  wire logic                        dot_fast_jmp,
	output logic [ADDR_W-1:0]                addr_out,
	output logic                             prog_rom_sel,
	input  wire logic [DATA_W-1:0]           prog_rom_data,
	output logic                             ctl_sel,
	output logic                             ctl_read_not_write,
	output logic [DATA_W-1:0]                ctl_wdata,
	input  wire logic [DATA_W-1:0]           ctl_rdata,
	output logic                             char_clk_en,
	input  wire logic [RAM_AW-1:0]           ctl_refresh_addr,
	input  wire logic [ROW_W-1:0]            ctl_row_addr,
	input  wire logic                        ctl_hsync,
	input  wire logic                        ctl_vsync,
	input  wire logic                        ctl_display_en,
	output logic [CODE_W+ROW_W-1:0]          font_addr,
	input  wire logic [FONT_BITS-1:0]        font_row_bits,
	output logic                             video_out,
	output logic                             hsync_out,
	output logic                             vsync_out,
	output logic [1:0]                       composite_level
);
	// Every backplane pin and jumper crosses into clk through two flops.
	typedef struct packed {
		logic [ADDR_W-1:0]         addr_n;
		logic                      bank_n;
		logic                      rw;
		logic                      act_n;
		logic                      phi2;
		logic                      brst_n;
		logic [DATA_W-1:0]         data_n;
		logic [ADDR_W-BLK_LSB-1:0] base;
		logic                      bsel;
		logic                      bonly;
		logic                      romdis;
		logic                      dotsel;
	} cvb_pins_type;

	typedef struct packed {
		cvb_pins_type                    s1;
		cvb_pins_type                    s2;
		logic                            phi2_prev;
		logic                            rw_prev;
		logic [ADDR_W-1:0]               aout;
		logic [DATA_W-1:0]               wdata;
		logic [RAM_BYTES-1:0][DATA_W-1:0] ram;
		logic [CODE_W-1:0]               code;
		logic [CODE_W+ROW_W-1:0]         faddr;
		logic [DATA_W-1:0]               dout;
		logic                            oe;
		logic                            de;
		logic                            vid;
		logic                            hs;
		logic                            vs;
		logic [1:0]                      lvl;
	} cvb_top_type;

	cvb_top_type          q, n;
	cvb_pins_type         pins;
	logic [RAM_AW-1:0]    rd_idx;
	logic [DATA_W-1:0]    rd_byte;
	logic [DATA_W-1:0]    stat;
	logic [DATA_W-1:0]    src;
	logic                 ram_we;
	logic                 any_sel;

	cvb_link_if lnk ();

	cvb_decode u_decode (
		.clk   (clk),
		.rst_n (rst_n),
		.lnk   (lnk)
	);

	cvb_dotgen u_dotgen (
		.clk   (clk),
		.rst_n (rst_n),
		.lnk   (lnk)
	);

	assign pins = {bus_addr_n, bank_address_n, bus_read_not_write, bus_active_n,
		bus_phase2, bus_reset_n, bus_data_n_in, base_select_jmp, bank_select_jmp,
		bank_only_jmp, rom_disable_jmp, dot_fast_jmp};

	assign lnk.addr      = ~q.s2.addr_n;
	assign lnk.bank      = ~q.s2.bank_n;
	assign lnk.rw        = q.s2.rw;
	assign lnk.phi2      = q.s2.phi2;
	assign lnk.base      = q.s2.base;
	assign lnk.bank_sel  = q.s2.bsel;
	assign lnk.bank_only = q.s2.bonly;
	assign lnk.rom_dis   = q.s2.romdis;
	assign lnk.dot_sel   = q.s2.dotsel;

	// Rows past the last font row come out blank rather than aliasing another glyph.
	assign lnk.pattern = (q.faddr[ROW_W-1:0] < FONT_ROWS) ? font_row_bits : '0;

	always_comb begin
		any_sel = lnk.ram_sel || lnk.io_sel || lnk.rom_sel;
		// Selects are a flop behind the pins, so the write lands on the edge
		// after phase two falls, using the address and data held while it was high.
		ram_we = q.phi2_prev && !q.s2.phi2 && lnk.ram_sel && !q.rw_prev;
		rd_idx = lnk.ram_sel ? q.aout[RAM_AW-1:0] : ctl_refresh_addr;
		rd_byte = q.ram[rd_idx];
		stat = '0;
		stat[DE_BIT] = q.de;
		src = '0;
		if (lnk.ram_sel) begin
			src = rd_byte;
		end else if (lnk.io_sel) begin
			src = q.aout[STATUS_SEL_BIT] ? stat : ctl_rdata;
		end else if (lnk.rom_sel) begin
			src = prog_rom_data;
		end
	end

	always_comb begin
		n = q;
		n.s1 = pins;
		n.s2 = q.s1;
		n.phi2_prev = q.s2.phi2;
		n.rw_prev = q.s2.rw;
		// Address and data are only trusted while phase two is high.
		if (q.s2.phi2) begin
			n.aout = ~q.s2.addr_n;
			n.wdata = ~q.s2.data_n;
		end
		if (ram_we) begin
			n.ram[q.aout[RAM_AW-1:0]] = q.wdata;
		end
		n.dout = ~src;
		n.oe = !q.s2.act_n && q.s2.rw && q.s2.phi2 && any_sel;
		// During a bus RAM access the fetch sees the bus byte; the glyph may flicker.
		if (lnk.char_en) begin
			n.code = rd_byte;
		end
		n.faddr = {q.code, ctl_row_addr};
		n.de = ctl_display_en;
		n.vid = lnk.video && ctl_display_en;
		n.hs = ctl_hsync;
		n.vs = ctl_vsync;
		if (ctl_hsync || ctl_vsync) begin
			n.lvl = LVL_SYNC;
		end else if (lnk.video && ctl_display_en) begin
			n.lvl = LVL_WHITE;
		end else begin
			n.lvl = LVL_BLACK;
		end
		if (!q.s2.brst_n) begin
			n.oe = 1'b0;
			n.code = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign bus_data_n_out     = q.dout;
	assign bus_data_n_oe      = q.oe;
	assign addr_out           = q.aout;
	assign prog_rom_sel       = lnk.rom_sel;
	assign ctl_sel            = lnk.io_sel && !q.aout[STATUS_SEL_BIT];
	assign ctl_read_not_write = q.rw_prev;
	assign ctl_wdata          = q.wdata;
	assign char_clk_en        = lnk.char_en;
	assign font_addr          = q.faddr;
	assign video_out          = q.vid;
	assign hsync_out          = q.hs;
	assign vsync_out          = q.vs;
	assign composite_level    = q.lvl;

	property p_oe;
		@(posedge clk) disable iff (!rst_n)
		bus_data_n_oe |-> $past(!q.s2.act_n && q.s2.rw && q.s2.phi2 && q.s2.brst_n);
	endproperty
	a_oe: assert property (p_oe) else $error("Data driven outside an active read");

	property p_status;
		@(posedge clk) disable iff (!rst_n)
		lnk.io_sel && q.aout[STATUS_SEL_BIT]
			|=> bus_data_n_out[DE_BIT] == !$past(q.de);
	endproperty
	a_status: assert property (p_status) else $error("Status port wrong");

	property p_latch;
		@(posedge clk) disable iff (!rst_n)
		lnk.char_en && !lnk.ram_sel && q.s2.brst_n
			|=> q.code == $past(q.ram[ctl_refresh_addr]);
	endproperty
	a_latch: assert property (p_latch) else $error("Latch missed refresh byte");

	property p_bus_wins;
		@(posedge clk) disable iff (!rst_n)
		lnk.char_en && lnk.ram_sel && q.s2.brst_n
			|=> q.code == $past(q.ram[q.aout[RAM_AW-1:0]]);
	endproperty
	a_bus_wins: assert property (p_bus_wins) else $error("Refresh beat the bus");

	property p_ram_write;
		@(posedge clk) disable iff (!rst_n)
		ram_we |=> q.ram[$past(q.aout[RAM_AW-1:0])] == $past(q.wdata);
	endproperty
	a_ram_write: assert property (p_ram_write) else $error("RAM write lost");

	property p_font;
		@(posedge clk) disable iff (!rst_n)
		font_addr == {$past(q.code), $past(ctl_row_addr)};
	endproperty
	a_font: assert property (p_font) else $error("Font address wrong");

	property p_sync;
		@(posedge clk) disable iff (!rst_n)
		ctl_hsync || ctl_vsync |=> composite_level == LVL_SYNC && (hsync_out || vsync_out);
	endproperty
	a_sync: assert property (p_sync) else $error("Composite sync missing");

	property p_addr_pass;
		@(posedge clk) disable iff (!rst_n)
		q.s2.phi2 |=> addr_out == ~$past(q.s2.addr_n);
	endproperty
	a_addr_pass: assert property (p_addr_pass) else $error("Address not passed on");

	property p_wdata;
		@(posedge clk) disable iff (!rst_n)
		q.s2.phi2 |=> ctl_wdata == ~$past(q.s2.data_n);
	endproperty
	a_wdata: assert property (p_wdata) else $error("Write data not restored");

	property p_oe_sel;
		@(posedge clk) disable iff (!rst_n)
		bus_data_n_oe |-> $past(any_sel);
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("Data driven without a select");

	// The bus byte must come back even while a refresh fetch wants the RAM.
	property p_ram_read;
		@(posedge clk) disable iff (!rst_n)
		lnk.ram_sel |=> bus_data_n_out == ~$past(q.ram[q.aout[RAM_AW-1:0]]);
	endproperty
	a_ram_read: assert property (p_ram_read) else $error("Bus RAM read wrong");

	property p_rom_read;
		@(posedge clk) disable iff (!rst_n)
		lnk.rom_sel |=> bus_data_n_out == ~$past(prog_rom_data);
	endproperty
	a_rom_read: assert property (p_rom_read) else $error("ROM read data wrong");

	property p_ctl_read;
		@(posedge clk) disable iff (!rst_n)
		lnk.io_sel && !q.aout[STATUS_SEL_BIT]
			|=> bus_data_n_out == ~$past(ctl_rdata);
	endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("Controller read data wrong");

	// A backplane reset must silence the data lines whatever the bus is doing.
	property p_bus_reset;
		@(posedge clk) disable iff (!rst_n)
		!q.s2.brst_n |=> !bus_data_n_oe && q.code == '0;
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("Bus reset ignored");

	property p_blank_row;
		@(posedge clk) disable iff (!rst_n)
		q.faddr[ROW_W-1:0] >= FONT_ROWS |-> lnk.pattern == '0;
	endproperty
	a_blank_row: assert property (p_blank_row) else $error("Row past font not blank");

	property p_video_gate;
		@(posedge clk) disable iff (!rst_n)
		!ctl_display_en |=> !video_out;
	endproperty
	a_video_gate: assert property (p_video_gate) else $error("Video outside display");

	property p_video_pass;
		@(posedge clk) disable iff (!rst_n)
		ctl_display_en |=> video_out == $past(lnk.video);
	endproperty
	a_video_pass: assert property (p_video_pass) else $error("Video bit lost");

	property p_sync_pass;
		@(posedge clk) disable iff (!rst_n)
		hsync_out == $past(ctl_hsync) && vsync_out == $past(ctl_vsync);
	endproperty
	a_sync_pass: assert property (p_sync_pass) else $error("Sync outputs wrong");

	property p_white;
		@(posedge clk) disable iff (!rst_n)
		!ctl_hsync && !ctl_vsync && lnk.video && ctl_display_en
			|=> composite_level == LVL_WHITE;
	endproperty
	a_white: assert property (p_white) else $error("Composite white missing");

	property p_black;
		@(posedge clk) disable iff (!rst_n)
		!(ctl_hsync || ctl_vsync || (lnk.video && ctl_display_en))
			|=> composite_level == LVL_BLACK;
	endproperty
	a_black: assert property (p_black) else $error("Composite black missing");

	c_ram_wr: cover property (@(posedge clk) disable iff (!rst_n) ram_we);
	c_stat: cover property (@(posedge clk) disable iff (!rst_n)
		lnk.io_sel && q.aout[STATUS_SEL_BIT] && q.de);
	c_read: cover property (@(posedge clk) disable iff (!rst_n) bus_data_n_oe);
endmodule : cvb_top

// ===== pkg/cvb_pkg.sv
package cvb_pkg;
	localparam int CLK_MHZ       = 25;
	localparam int DOT_LO_MHZ    = 6;
	localparam int DOT_HI_MHZ    = 12;
	localparam int ACC_W         = 6;
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_MHZ);
	localparam logic [ACC_W-1:0] STEP_LO = ACC_W'(DOT_LO_MHZ);
	localparam logic [ACC_W-1:0] STEP_HI = ACC_W'(DOT_HI_MHZ);
	localparam int DOTS_PER_CHAR = 7;
	localparam int DIV_W         = 3;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DOTS_PER_CHAR - 1);
	localparam logic [DIV_W-1:0] DIV_ONE  = DIV_W'(1);
	localparam int FONT_BITS     = 7;
	localparam int FONT_CODES    = 256;
	localparam int CODE_W        = $clog2(FONT_CODES);
	localparam int ROW_W         = 4;
	localparam logic [ROW_W-1:0] FONT_ROWS = ROW_W'(10);
	localparam int ADDR_W        = 16;
	localparam int DATA_W        = 8;
	localparam int BLK_LSB       = 12;
	localparam int HALF_BIT      = 11;
	localparam int PAGE_LSB      = 8;
	localparam logic [HALF_BIT-PAGE_LSB:0] IO_PAGE = 4'h8;
	localparam int RAM_BYTES     = 2048;
	localparam int RAM_AW        = $clog2(RAM_BYTES);
	localparam int STATUS_SEL_BIT = 7;
	localparam int DE_BIT        = 0;
	localparam logic [1:0] LVL_SYNC  = 2'h0;
	localparam logic [1:0] LVL_BLACK = 2'h1;
	localparam logic [1:0] LVL_WHITE = 2'h2;
endpackage : cvb_pkg

// ===== pkg/cvb_link_if.sv
`timescale 1ns/1ps
interface cvb_link_if import cvb_pkg::*; ();
	logic [ADDR_W-1:0]         addr;
	logic                      bank;
	logic                      rw;
	logic                      phi2;
	logic [ADDR_W-BLK_LSB-1:0] base;
	logic                      bank_sel;
	logic                      bank_only;
	logic                      rom_dis;
	logic                      ram_sel;
	logic                      io_sel;
	logic                      rom_sel;
	logic                      dot_sel;
	logic [FONT_BITS-1:0]      pattern;
	logic                      dot_en;
	logic                      char_en;
	logic                      video;
	modport dec (input addr, bank, rw, phi2, base, bank_sel, bank_only, rom_dis,
		output ram_sel, io_sel, rom_sel);
	modport vid (input dot_sel, pattern, output dot_en, char_en, video);
endinterface : cvb_link_if

// ===== rtl/cvb_decode.sv
`timescale 1ns/1ps
module cvb_decode
	import cvb_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	cvb_link_if.dec   lnk
);
	typedef struct packed {
		logic ram;
		logic io;
		logic rom;
	} cvb_dec_type;

	cvb_dec_type         q, n;
	logic                in_bank;
	logic                go;
	logic [BLK_LSB-1:0]  off;
	logic                io_page;

	always_comb begin
		off = lnk.addr[BLK_LSB-1:0];
		in_bank = !lnk.bank_only || (lnk.bank == lnk.bank_sel);
		go = in_bank && lnk.addr[ADDR_W-1:BLK_LSB] == lnk.base && lnk.phi2;
		io_page = off[HALF_BIT:PAGE_LSB] == IO_PAGE;
		n.ram = go && !off[HALF_BIT];
		n.io = go && io_page;
		// The ROM is read-only, so a write there leaves the bus undriven.
		n.rom = go && lnk.rw && !lnk.rom_dis && off[HALF_BIT] && !io_page;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign lnk.ram_sel = q.ram;
	assign lnk.io_sel  = q.io;
	assign lnk.rom_sel = q.rom;

	property p_rom_off;
		@(posedge clk) disable iff (!rst_n)
		lnk.rom_sel |-> $past(!lnk.rom_dis && lnk.rw && lnk.addr[HALF_BIT]);
	endproperty
	a_rom_off: assert property (p_rom_off) else $error("ROM selected while disabled");

	property p_block;
		@(posedge clk) disable iff (!rst_n)
		(lnk.ram_sel || lnk.io_sel || lnk.rom_sel)
			|-> $past(lnk.addr[ADDR_W-1:BLK_LSB] == lnk.base && lnk.phi2);
	endproperty
	a_block: assert property (p_block) else $error("Select outside base block");

	property p_bank;
		@(posedge clk) disable iff (!rst_n)
		(lnk.ram_sel || lnk.io_sel) |-> $past(!lnk.bank_only || lnk.bank == lnk.bank_sel);
	endproperty
	a_bank: assert property (p_bank) else $error("Select in wrong bank");

	property p_onehot;
		@(posedge clk) disable iff (!rst_n)
		$onehot0({lnk.ram_sel, lnk.io_sel, lnk.rom_sel});
	endproperty
	a_onehot: assert property (p_onehot) else $error("Overlapping selects");

	c_rom: cover property (@(posedge clk) disable iff (!rst_n) lnk.rom_sel);
endmodule : cvb_decode

// ===== rtl/cvb_dotgen.sv
`timescale 1ns/1ps
module cvb_dotgen
	import cvb_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	cvb_link_if.vid   lnk
);
	typedef struct packed {
		logic [ACC_W-1:0]     acc;
		logic [DIV_W-1:0]     div;
		logic [FONT_BITS-1:0] sr;
		logic                 dot;
		logic                 chr;
		logic                 vid;
	} cvb_dot_type;

	cvb_dot_type      q, n;
	logic [ACC_W-1:0] sum;
	logic [DIV_W-1:0] dots_seen;

	// A phase accumulator gives the dot rate on average; single dots jitter by one clock.
	always_comb begin
		n = q;
		n.dot = 1'b0;
		n.chr = 1'b0;
		sum = q.acc + (lnk.dot_sel ? STEP_HI : STEP_LO);
		n.acc = sum;
		if (sum >= ACC_MOD) begin
			n.acc = sum - ACC_MOD;
			n.dot = 1'b1;
			n.div = q.div + DIV_ONE;
			if (q.div == DIV_LAST) begin
				n.div = '0;
				n.chr = 1'b1;
			end
			n.vid = n.chr ? lnk.pattern[FONT_BITS-1] : q.sr[FONT_BITS-1];
			n.sr = (n.chr ? lnk.pattern : q.sr) << 1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign lnk.dot_en  = q.dot;
	assign lnk.char_en = q.chr;
	assign lnk.video   = q.vid;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dots_seen <= '0;
		end else if (lnk.char_en) begin
			dots_seen <= '0;
		end else if (lnk.dot_en) begin
			dots_seen <= dots_seen + DIV_ONE;
		end
	end

	property p_div;
		@(posedge clk) disable iff (!rst_n)
		lnk.char_en |-> lnk.dot_en && dots_seen == DIV_LAST;
	endproperty
	a_div: assert property (p_div) else $error("Character clock not dot clock by seven");

	property p_rate_hi;
		@(posedge clk) disable iff (!rst_n)
		lnk.dot_sel && lnk.dot_en |-> ##[1:3] lnk.dot_en;
	endproperty
	a_rate_hi: assert property (p_rate_hi) else $error("Fast dot rate too slow");

	property p_rate_lo;
		@(posedge clk) disable iff (!rst_n)
		!lnk.dot_sel && lnk.dot_en |=> !lnk.dot_en;
	endproperty
	a_rate_lo: assert property (p_rate_lo) else $error("Slow dot rate too fast");

	property p_load;
		@(posedge clk) disable iff (!rst_n)
		lnk.char_en |-> lnk.video == $past(lnk.pattern[FONT_BITS-1]);
	endproperty
	a_load: assert property (p_load) else $error("Pattern not loaded on character");

	c_char: cover property (@(posedge clk) disable iff (!rst_n) lnk.char_en && lnk.video);
endmodule : cvb_dotgen

// ===== testbench/cvb_host_model.sv
`timescale 1ns/1ps
module cvb_host_model
	import cvb_pkg::*;
(
	input  wire logic              clk,
	output logic [ADDR_W-1:0]      bus_addr_n,
	output logic                   bank_address_n,
	output logic                   bus_read_not_write,
	output logic                   bus_active_n,
	output logic                   bus_phase2,
	output logic [DATA_W-1:0]      bus_data_n_in,
	input  wire logic [DATA_W-1:0] bus_data_n_out,
	input  wire logic              bus_data_n_oe,
	input  wire logic [ADDR_W-1:0] addr_out
);
	logic [ADDR_W-1:0] last_addr;
	int                ph_len;

	initial begin
		bus_addr_n         = '1;
		bank_address_n     = 1'h1;
		bus_read_not_write = 1'h1;
		bus_active_n       = 1'h1;
		bus_phase2         = 1'h0;
		bus_data_n_in      = '1;
		last_addr          = '0;
		ph_len             = 6;
	end

	// One bus cycle; rd and seen report what the slave drove during phase two.
	task automatic cyc(input logic [ADDR_W-1:0] a, input logic bk, input logic rw,
		input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output logic seen);
		seen = 1'h0;
		rd   = '0;
		@(posedge clk);
		bus_addr_n         <= ~a;
		bank_address_n     <= ~bk;
		bus_read_not_write <= rw;
		bus_data_n_in      <= ~wd;
		bus_active_n       <= 1'h0;
		bus_phase2         <= 1'h1;
		repeat (ph_len) begin
			@(posedge clk);
			last_addr = addr_out;
			if (bus_data_n_oe === 1'h1) begin
				seen = 1'h1;
				rd   = ~bus_data_n_out;
			end
		end
		// Address, bank and direction stay put past the fall, since writes land late.
		bus_phase2 <= 1'h0;
		repeat (6) @(posedge clk);
		// Released lines show the inverse of their last value, so a stale level cannot pass.
		bus_active_n   <= 1'h1;
		bus_addr_n     <= a;
		bank_address_n <= bk;
		bus_data_n_in  <= wd;
	endtask : cyc
endmodule : cvb_host_model

// ===== testbench/tb_cvb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module tb_cvb_top
	import cvb_pkg::*;
();
	logic clk = 1'h0, rst_n = 1'h0, bus_reset_n = 1'h1;
	logic [ADDR_W-1:0] bus_addr_n, addr_out;
	logic bank_address_n, bus_read_not_write, bus_active_n, bus_phase2, bus_data_n_oe;
	logic [DATA_W-1:0] bus_data_n_in, bus_data_n_out, prog_rom_data, ctl_wdata;
	logic [DATA_W-1:0] ctl_rdata = 8'h3c;
	logic [ADDR_W-BLK_LSB-1:0] base_select_jmp = 4'ha;
	logic bank_select_jmp = 1'h0, bank_only_jmp = 1'h0, rom_disable_jmp = 1'h0;
	logic dot_fast_jmp = 1'h0, ctl_hsync = 1'h0, ctl_vsync = 1'h0, ctl_display_en = 1'h0;
	logic [RAM_AW-1:0] ctl_refresh_addr = '0;
	logic [ROW_W-1:0] ctl_row_addr = '0;
	logic [FONT_BITS-1:0] font_row_bits = '0;
	logic [CODE_W+ROW_W-1:0] font_addr;
	logic prog_rom_sel, ctl_sel, ctl_read_not_write, char_clk_en;
	logic video_out, hsync_out, vsync_out, vid_q;
	logic [1:0] composite_level;
	int mismatches = 0, num_checks = 0, chr_n = 0, rise_n = 0, rom_n = 0, ctl_n = 0, wht_n = 0;
	int r, c, v;

	// The program ROM stand-in returns the inverted low address byte.
	assign prog_rom_data = ~addr_out[7:0];

	initial forever #20 clk = ~clk;

	cvb_host_model host (.clk(clk), .bus_addr_n(bus_addr_n), .bank_address_n(bank_address_n),
		.bus_read_not_write(bus_read_not_write), .bus_active_n(bus_active_n),
		.bus_phase2(bus_phase2), .bus_data_n_in(bus_data_n_in),
		.bus_data_n_out(bus_data_n_out), .bus_data_n_oe(bus_data_n_oe), .addr_out(addr_out));

	cvb_top dut (.clk(clk), .rst_n(rst_n), .bus_addr_n(bus_addr_n),
		.bank_address_n(bank_address_n), .bus_read_not_write(bus_read_not_write),
		.bus_active_n(bus_active_n), .bus_phase2(bus_phase2), .bus_reset_n(bus_reset_n),
		.bus_data_n_in(bus_data_n_in), .bus_data_n_out(bus_data_n_out),
		.bus_data_n_oe(bus_data_n_oe), .base_select_jmp(base_select_jmp),
		.bank_select_jmp(bank_select_jmp), .bank_only_jmp(bank_only_jmp),
		.rom_disable_jmp(rom_disable_jmp), .dot_fast_jmp(dot_fast_jmp),
		.addr_out(addr_out), .prog_rom_sel(prog_rom_sel), .prog_rom_data(prog_rom_data),
		.ctl_sel(ctl_sel), .ctl_read_not_write(ctl_read_not_write), .ctl_wdata(ctl_wdata),
		.ctl_rdata(ctl_rdata), .char_clk_en(char_clk_en), .ctl_refresh_addr(ctl_refresh_addr),
		.ctl_row_addr(ctl_row_addr), .ctl_hsync(ctl_hsync), .ctl_vsync(ctl_vsync),
		.ctl_display_en(ctl_display_en), .font_addr(font_addr),
		.font_row_bits(font_row_bits), .video_out(video_out), .hsync_out(hsync_out),
		.vsync_out(vsync_out), .composite_level(composite_level));

	always @(posedge clk) begin
		if (char_clk_en === 1'h1) chr_n++;
		if (video_out === 1'h1 && vid_q !== 1'h1) rise_n++;
		if (prog_rom_sel === 1'h1) rom_n++;
		if (ctl_sel === 1'h1) ctl_n++;
		if (composite_level === LVL_WHITE) wht_n++;
		vid_q = video_out;
	end

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// Checks that drive was seen exactly when xs is set; the read byte is compared with xd only when drive is expected.
	task automatic acc(input logic [ADDR_W-1:0] a, input logic bk, input logic rw,
		input logic [DATA_W-1:0] wd, input logic xs, input logic [DATA_W-1:0] xd);
		logic [DATA_W-1:0] d;
		logic              s;
		host.cyc(a, bk, rw, wd, d, s);
		`CHK(s, xs)
		if (xs) `CHK(d, xd)
	endtask : acc

	task automatic wait_char();
		int i;
		for (i = 0; i < 60 && char_clk_en !== 1'h1; i++) @(posedge clk);
		if (i == 60) begin
			mismatches++;
			end_sim();
		end
		@(posedge clk);
	endtask : wait_char

	// Counts character pulses and video rising edges over n cycles.
	task automatic win(input int n, output int dc, output int dv);
		int c0, v0;
		c0 = chr_n;
		v0 = rise_n;
		repeat (n) @(posedge clk);
		dc = chr_n - c0;
		dv = rise_n - v0;
	endtask : win

	initial begin
		repeat (5) @(posedge clk);
		`CHK(bus_data_n_oe, 1'h0)
		`CHK(composite_level, LVL_SYNC)
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		acc(16'ha000, 1'h0, 1'h0, 8'h5a, 1'h0, '0);
		acc(16'ha7ff, 1'h0, 1'h0, 8'hc3, 1'h0, '0);
		acc(16'ha000, 1'h0, 1'h1, '0, 1'h1, 8'h5a);
		`CHK(host.last_addr, 16'ha000)
		host.ph_len = 9;
		acc(16'ha7ff, 1'h0, 1'h1, '0, 1'h1, 8'hc3);
		host.ph_len = 6;
		acc(16'ha801, 1'h0, 1'h1, '0, 1'h1, 8'h3c);
		`CHK(ctl_read_not_write, 1'h1)
		r = ctl_n;
		acc(16'ha802, 1'h0, 1'h0, 8'h77, 1'h0, '0);
		`CHK(ctl_wdata, 8'h77)
		`CHK(ctl_read_not_write, 1'h0)
		`CHK(ctl_n > r, 1'h1)
		acc(16'ha880, 1'h0, 1'h1, '0, 1'h1, 8'h00);
		ctl_display_en <= 1'h1;
		acc(16'ha880, 1'h0, 1'h1, '0, 1'h1, 8'h01);
		r = rom_n;
		acc(16'ha9f0, 1'h0, 1'h1, '0, 1'h1, 8'h0f);
		acc(16'hafff, 1'h0, 1'h1, '0, 1'h1, 8'h00);
		`CHK(rom_n > r, 1'h1)
		r = rom_n;
		acc(16'ha9f0, 1'h0, 1'h0, 8'h11, 1'h0, '0);
		`CHK(rom_n, r)
		rom_disable_jmp <= 1'h1;
		acc(16'ha9f0, 1'h0, 1'h1, '0, 1'h0, '0);
		acc(16'ha880, 1'h0, 1'h1, '0, 1'h1, 8'h01);
		acc(16'ha000, 1'h0, 1'h1, '0, 1'h1, 8'h5a);
		`CHK(rom_n, r)
		rom_disable_jmp <= 1'h0;
		acc(16'hb000, 1'h0, 1'h1, '0, 1'h0, '0);
		base_select_jmp <= 4'h3;
		acc(16'h3000, 1'h0, 1'h1, '0, 1'h1, 8'h5a);
		acc(16'ha000, 1'h0, 1'h1, '0, 1'h0, '0);
		bank_only_jmp <= 1'h1;
		bank_select_jmp <= 1'h1;
		acc(16'h3000, 1'h0, 1'h1, '0, 1'h0, '0);
		acc(16'h3000, 1'h1, 1'h1, '0, 1'h1, 8'h5a);
		bank_select_jmp <= 1'h0;
		acc(16'h3000, 1'h0, 1'h1, '0, 1'h1, 8'h5a);
		acc(16'h3000, 1'h1, 1'h1, '0, 1'h0, '0);
		bank_only_jmp <= 1'h0;
		acc(16'h3000, 1'h1, 1'h1, '0, 1'h1, 8'h5a);
		bus_reset_n <= 1'h0;
		acc(16'h3000, 1'h0, 1'h1, '0, 1'h0, '0);
		bus_reset_n <= 1'h1;
		acc(16'h3000, 1'h0, 1'h1, '0, 1'h1, 8'h5a);
		for (int f = 0; f < 2; f++) begin
			dot_fast_jmp <= f[0];
			repeat (20) @(posedge clk);
			win(700, c, v);
			r = 700 * (f ? DOT_HI_MHZ : DOT_LO_MHZ) / CLK_MHZ / DOTS_PER_CHAR;
			`CHK(c >= r - 1 && c <= r + 1, 1'h1)
		end
		acc(16'h3123, 1'h0, 1'h0, 8'h9c, 1'h0, '0);
		ctl_refresh_addr <= 11'h123;
		ctl_row_addr <= 4'h6;
		wait_char();
		wait_char();
		repeat (3) @(posedge clk);
		`CHK(font_addr, {8'h9c, 4'h6})
		font_row_bits <= 7'h40;
		wait_char();
		wait_char();
		r = wht_n;
		win(350, c, v);
		`CHK(v >= c - 1 && v <= c + 1 && c > 0, 1'h1)
		`CHK(wht_n > r, 1'h1)
		ctl_row_addr <= 4'ha;
		wait_char();
		wait_char();
		wait_char();
		win(350, c, v);
		`CHK(v, 0)
		ctl_hsync <= 1'h1;
		repeat (4) @(posedge clk);
		`CHK(hsync_out, 1'h1)
		`CHK(composite_level, LVL_SYNC)
		ctl_hsync <= 1'h0;
		ctl_vsync <= 1'h1;
		repeat (4) @(posedge clk);
		`CHK(vsync_out, 1'h1)
		`CHK(hsync_out, 1'h0)
		ctl_vsync <= 1'h0;
		repeat (4) @(posedge clk);
		`CHK(composite_level, LVL_BLACK)
		end_sim();
	end
endmodule : tb_cvb_top
